// File: sra_pkg.sv
package sra_pkg;

  // ----------------------------------------------------------------
  // Sizes and limits
  // ----------------------------------------------------------------
  localparam int          NUM_CH_DEF    = 4;
  localparam int          HIST_W        = 32;
  localparam logic [2:0]  EQ_MAX        = 3'h4;
  localparam logic [2:0]  EQ_RESET      = 3'h0;
  localparam logic [10:0] PPM_BASE      = 11'h07d;
  localparam logic [7:0]  PHASE_TOL_MUI = 8'h50;
  localparam logic [7:0]  RL_STEP10     = 8'h05;
  localparam logic [7:0]  RL_STEP8      = 8'h04;
  localparam logic [3:0]  WLEN10_M1     = 4'h9;
  localparam logic [3:0]  WLEN8_M1      = 4'h7;
  localparam logic [9:0]  K28P5_NEG     = 10'h17c;
  localparam logic [1:0]  SYNC_COMMAS   = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_LOCK_NS   = 2000;
  localparam int REF_LOCK_CYC  =
    (REF_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PROTO_CUSTOM = 2'h0,
    PROTO_SONET  = 2'h1,
    PROTO_XAUI   = 2'h2,
    PROTO_GIGE   = 2'h3
  } sra_proto_t;

  typedef enum logic [2:0] {
    AL_BITSLIP = 3'h0,
    AL_16BIT   = 3'h1,
    AL_10BIT   = 3'h2,
    AL_XAUI    = 3'h3,
    AL_GIGE    = 3'h4
  } sra_align_t;

  typedef enum logic [2:0] {
    LK_OFF  = 3'b001,
    LK_REF  = 3'b010,
    LK_DATA = 3'b100
  } sra_lock_st_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    sra_proto_t  proto;
    sra_align_t  align_mode;
    logic        width10;
    logic        dbl;
    logic        pat7;
    logic        pat_double;
    logic [9:0]  user_pat;
    logic [15:0] user_pat16;
    logic [1:0]  ppm_sel;
    logic [4:0]  rl_steps;
    logic        eq_dynamic;
  } sra_cfg_t;

  typedef struct packed {
    logic        ser_bit;
    logic        ser_valid;
    logic        ch_used;
    logic        force_data;
    logic        force_ref;
    logic        bitslip;
    logic        realign;
    logic        align_en;
    logic [2:0]  eq_ctrl;
    logic [10:0] ppm_dev;
    logic [7:0]  phase_mui;
  } sra_ch_in_t;

  typedef struct packed {
    logic [19:0] word;
    logic        word_valid;
    logic        pat_det;
    logic        sync;
    logic        run_err;
    logic [2:0]  eq_level;
    logic        cdr_pwr_en;
    logic        pll_locked_n;
    logic        freq_locked;
  } sra_ch_out_t;

endpackage

// File: sra_cdr_lock.sv
`timescale 1ns/1ns
module sra_cdr_lock
  import sra_pkg::*;
#(
  parameter int LOCK_CYC = REF_LOCK_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ch_used,
  input  wire logic        force_data,
  input  wire logic        force_ref,
  input  wire logic [10:0] ppm_dev,
  input  wire logic [7:0]  phase_mui,
  input  wire logic [1:0]  ppm_sel,
  output logic             cdr_pwr_en,
  output logic             pll_locked_n,
  output logic             freq_locked
);

  logic         fd_meta_reg;
  logic         fd_sync_reg;
  logic         fr_meta_reg;
  logic         fr_sync_reg;
  logic [15:0]  lock_cnt_reg;
  logic         pll_locked_n_reg;
  logic         freq_locked_reg;
  sra_lock_st_t state_reg;
  sra_lock_st_t state_next;
  wire  [10:0]  ppm_thr;
  wire          ppm_ok;
  wire          phase_ok;
  wire          ref_locked;

  // ----------------------------------------------------------------
  // Override synchronisers
  // ----------------------------------------------------------------
  // A glitch on a half-settled override could flip the oscillator mode.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fd_meta_reg <= 1'b0;
      fd_sync_reg <= 1'b0;
      fr_meta_reg <= 1'b0;
      fr_sync_reg <= 1'b0;
    end else begin
      fd_meta_reg <= force_data;
      fd_sync_reg <= fd_meta_reg;
      fr_meta_reg <= force_ref;
      fr_sync_reg <= fr_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Lock conditions
  // ----------------------------------------------------------------
  assign ppm_thr    = PPM_BASE << ppm_sel;
  assign ppm_ok     = ppm_dev <= ppm_thr;
  assign phase_ok   = phase_mui <= PHASE_TOL_MUI;
  assign ref_locked = lock_cnt_reg == 16'(LOCK_CYC);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_reg <= 16'h0000;
    end else if (state_next == LK_OFF) begin
      lock_cnt_reg <= 16'h0000;
    end else if (!ref_locked) begin
      lock_cnt_reg <= lock_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Switchover state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LK_OFF: begin
        state_next = LK_REF;
      end
      LK_REF: begin
        if (fd_sync_reg) begin
          state_next = LK_DATA;
        end else if (!fr_sync_reg && ref_locked && ppm_ok && phase_ok) begin
          state_next = LK_DATA;
        end
      end
      LK_DATA: begin
        if (!fd_sync_reg && (fr_sync_reg || !ppm_ok)) begin
          state_next = LK_REF;
        end
      end
      default: begin
        state_next = LK_OFF;
      end
    endcase
    if (!ch_used) begin
      state_next = LK_OFF;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg        <= LK_OFF;
      pll_locked_n_reg <= 1'b1;
      freq_locked_reg  <= 1'b0;
    end else begin
      state_reg        <= state_next;
      pll_locked_n_reg <= !(ref_locked && state_next != LK_OFF);
      freq_locked_reg  <= state_next == LK_DATA;
    end
  end

  assign cdr_pwr_en   = state_reg != LK_OFF;
  assign pll_locked_n = pll_locked_n_reg;
  assign freq_locked  = freq_locked_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_force_data_wins: assert property (
    ch_used && fd_sync_reg && state_reg != LK_OFF |=> freq_locked)
    else $error("forced data lock not taken");
  chk_force_ref_holds: assert property (
    ch_used && !fd_sync_reg && fr_sync_reg && state_reg == LK_REF
    |=> state_reg == LK_REF)
    else $error("forced reference lock left");
  chk_auto_ppm: assert property (
    $rose(freq_locked) |-> $past(fd_sync_reg) || $past(ppm_ok))
    else $error("data lock taken outside ppm window");
  chk_auto_phase: assert property (
    $rose(freq_locked) |-> $past(fd_sync_reg) || $past(phase_ok))
    else $error("data lock taken outside phase window");
  chk_unused_off: assert property (
    !ch_used |=> !cdr_pwr_en && pll_locked_n && !freq_locked)
    else $error("unused channel not powered down");
  chk_override_sync: assert property (
    $rose(force_data) |=> !fd_sync_reg ##1 (fd_sync_reg || !$past(force_data)))
    else $error("override not passed through two stages");
  chk_lock_flag: assert property (
    freq_locked |-> state_reg == LK_DATA)
    else $error("frequency lock flag without data lock");
  chk_ref_lock_n: assert property (
    !pll_locked_n |-> $past(lock_cnt_reg) == 16'(LOCK_CYC))
    else $error("reference lock shown too early");

  cov_data_lock: cover property ($rose(freq_locked));
  cov_fall_back: cover property ($fell(freq_locked) && ch_used);

endmodule

// File: sra_rx_align.sv
`timescale 1ns/1ns
module sra_rx_align
  import sra_pkg::*;
#(
  parameter int         NUM_CH    = NUM_CH_DEF,
  parameter logic [2:0] EQ_STATIC = EQ_RESET
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire sra_cfg_t                 cfg,
  input  wire sra_ch_in_t  [NUM_CH-1:0] ch_in,
  output sra_ch_out_t      [NUM_CH-1:0] ch_out,
  output logic                          cfg_err
);

  // ----------------------------------------------------------------
  // Configuration checks
  // ----------------------------------------------------------------
  function automatic logic cfg_legal(sra_cfg_t c);
    logic cs;
    cs = c.proto == PROTO_CUSTOM || c.proto == PROTO_SONET;
    unique case (c.align_mode)
      AL_BITSLIP: return cs;
      AL_16BIT:   return cs && !c.width10 &&
                    (!c.pat_double || c.proto == PROTO_SONET);
      AL_10BIT:   return c.proto == PROTO_CUSTOM && c.width10;
      AL_XAUI:    return c.proto == PROTO_XAUI && c.width10;
      AL_GIGE:    return c.proto == PROTO_GIGE && c.width10;
      default:    return 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] rl_thr(logic [4:0] steps, logic w10);
    logic [7:0] n;
    n = {3'h0, steps} + 8'h01;
    return w10 ? 8'(n * RL_STEP10) : 8'(n * RL_STEP8);
  endfunction

  wire       legal   = cfg_legal(cfg);
  wire [3:0] wlen_m1 = cfg.width10 ? WLEN10_M1 : WLEN8_M1;
  wire [7:0] run_thr = rl_thr(cfg.rl_steps, cfg.width10);
  wire       fixed   = cfg.align_mode == AL_XAUI || cfg.align_mode == AL_GIGE;
  wire [9:0] pat10   = fixed ? K28P5_NEG : cfg.user_pat;
  wire [7:0] a1      = cfg.user_pat16[7:0];
  wire [7:0] a2      = cfg.user_pat16[15:8];

  assign cfg_err = !legal;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    sra_ch_in_t        ci;
    logic [HIST_W-1:0] hist_reg;
    logic [3:0]        bit_cnt_reg;
    logic              slip_q_reg;
    logic              slip_pend_reg;
    logic              pat_pend_reg;
    logic              sync_reg;
    logic [1:0]        comma_cnt_reg;
    logic              half_reg;
    logic [9:0]        low_reg;
    logic [19:0]       word_reg;
    logic              word_valid_reg;
    logic              pat_det_reg;
    logic              emit_reg;
    logic [7:0]        run_cnt_reg;
    logic              run_err_reg;
    logic [2:0]        eq_reg;
    logic              cdr_pwr_en;
    logic              pll_locked_n;
    logic              freq_locked;

    assign ci = ch_in[c];

    sra_cdr_lock u_lock (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .ch_used      (ci.ch_used),
      .force_data   (ci.force_data),
      .force_ref    (ci.force_ref),
      .ppm_dev      (ci.ppm_dev),
      .phase_mui    (ci.phase_mui),
      .ppm_sel      (cfg.ppm_sel),
      .cdr_pwr_en   (cdr_pwr_en),
      .pll_locked_n (pll_locked_n),
      .freq_locked  (freq_locked)
    );

    // Window of the newest bits; the oldest sits in bit 0.
    wire [HIST_W-1:0] hist_new = {ci.ser_bit, hist_reg[HIST_W-1:1]};
    wire [9:0] win10 = hist_new[31:22];
    wire [7:0] win8  = hist_new[31:24];
    wire [9:0] cur   = cfg.width10 ? win10 : {2'h0, win8};

    wire m_full = win10 == pat10 || win10 == ~pat10;
    wire m_low7 = win10[6:0] == pat10[6:0] ||
                  win10[6:0] == ~pat10[6:0];
    wire m10    = (cfg.pat7 && !fixed) ? m_low7 : m_full;
    wire m16    = cfg.pat_double ? hist_new == {a2, a2, a1, a1}
                                 : hist_new[31:16] == {a2, a1};
    wire mslip  = cfg.width10 ? win10 == cfg.user_pat
                              : win8 == cfg.user_pat[7:0];

    wire mode16  = cfg.align_mode == AL_16BIT;
    wire mode10  = cfg.align_mode == AL_10BIT;
    wire modebs  = cfg.align_mode == AL_BITSLIP;
    wire pat_hit = legal && ci.ser_valid &&
                   (modebs ? mslip : (mode16 ? m16 : m10));
    wire boundary = bit_cnt_reg == wlen_m1;

    // The 10-bit aligner follows every pattern while enabled; the 16-bit and
    // fixed aligners search only until they hold sync, and bit-slip never aligns.
    wire can_align = !modebs && (mode10 ? ci.align_en : !sync_reg);
    wire align_now = pat_hit && can_align;
    wire slip_req  = ci.bitslip && !slip_q_reg && modebs && legal;
    wire slip_take = ci.ser_valid && slip_pend_reg;
    wire emit      = ci.ser_valid && !slip_take && (boundary || align_now);
    wire misalign  = fixed && sync_reg && pat_hit && !boundary;

    wire [7:0] run_next = (hist_new[31] == hist_reg[31])
                          ? ((run_cnt_reg == 8'hff) ? 8'hff
                                                    : run_cnt_reg + 8'h01)
                          : 8'h01;

    // A stalled slip absorbs one bit into the current word.
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        hist_reg      <= '0;
        bit_cnt_reg   <= 4'h0;
        slip_q_reg    <= 1'b0;
        slip_pend_reg <= 1'b0;
      end else begin
        slip_q_reg    <= ci.bitslip;
        slip_pend_reg <= slip_req || (slip_pend_reg && !slip_take);
        if (ci.ser_valid) begin
          hist_reg <= hist_new;
          if (emit) begin
            bit_cnt_reg <= 4'h0;
          end else if (!slip_take) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
      end
    end

    // Sync: 16-bit drops on realign, fixed modes on a misplaced comma.
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        sync_reg      <= 1'b0;
        comma_cnt_reg <= 2'h0;
      end else if (!legal || (mode16 && ci.realign) || misalign) begin
        sync_reg      <= 1'b0;
        comma_cnt_reg <= 2'h0;
      end else if (fixed && pat_hit && (boundary || align_now)) begin
        comma_cnt_reg <= comma_cnt_reg + 2'h1;
        if (comma_cnt_reg + 2'h1 == SYNC_COMMAS) begin
          sync_reg <= 1'b1;
        end
      end else if (!fixed && pat_hit && emit) begin
        sync_reg <= 1'b1;
      end
    end

    // Word assembly and pairing for the double-width path.
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        half_reg       <= 1'b0;
        low_reg        <= 10'h000;
        word_reg       <= 20'h00000;
        word_valid_reg <= 1'b0;
        pat_det_reg    <= 1'b0;
        pat_pend_reg   <= 1'b0;
        emit_reg       <= 1'b0;
      end else begin
        emit_reg       <= emit;
        word_valid_reg <= emit && (!cfg.dbl || (half_reg && !align_now));
        pat_pend_reg   <= (pat_pend_reg && !emit) || (pat_hit && !emit);
        if (emit) begin
          // A pattern seen before the setting went illegal must not leak out.
          pat_det_reg <= legal && (pat_pend_reg || pat_hit);
          if (!cfg.dbl) begin
            word_reg <= {10'h000, cur};
          end else if (half_reg && !align_now) begin
            word_reg <= cfg.width10 ? {cur, low_reg}
                                    : {4'h0, cur[7:0], low_reg[7:0]};
            half_reg <= 1'b0;
          end else begin
            low_reg  <= cur;
            half_reg <= 1'b1;
          end
        end
      end
    end

    // Run length and equaliser.
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        run_cnt_reg <= 8'h00;
        run_err_reg <= 1'b0;
        eq_reg      <= EQ_RESET;
      end else begin
        run_err_reg <= 1'b0;
        if (ci.ser_valid) begin
          run_cnt_reg <= run_next;
          run_err_reg <= run_next == run_thr + 8'h01;
        end
        if (!cfg.eq_dynamic) begin
          eq_reg <= EQ_STATIC;
        end else if (ci.eq_ctrl <= EQ_MAX) begin
          eq_reg <= ci.eq_ctrl;
        end
      end
    end

    assign ch_out[c] = '{word:         word_reg,
                         word_valid:   word_valid_reg,
                         pat_det:      pat_det_reg,
                         sync:         sync_reg,
                         run_err:      run_err_reg,
                         eq_level:     eq_reg,
                         cdr_pwr_en:   cdr_pwr_en,
                         pll_locked_n: pll_locked_n,
                         freq_locked:  freq_locked};

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    chk_slip_holds: assert property (
      slip_take |=> bit_cnt_reg == $past(bit_cnt_reg))
      else $error("slip did not hold the bit count");
    chk_bitslip_fixed: assert property (
      modebs && pat_hit && !boundary |=> !emit_reg)
      else $error("pattern moved the boundary in bit-slip mode");
    chk_lsb_first: assert property (
      emit && !cfg.dbl && cfg.width10 |=> word_reg[9] == $past(ci.ser_bit))
      else $error("newest bit not at the top of the word");
    chk_sync_sticky: assert property (
      sync_reg && mode10 && legal && $stable(cfg) |=> sync_reg)
      else $error("10-bit sync dropped");
    chk_realign: assert property (
      mode16 && ci.realign |=> !sync_reg)
      else $error("realign did not restart search");
    chk_eq_range: assert property (
      eq_reg <= EQ_MAX)
      else $error("equaliser level out of range");
    chk_illegal_idle: assert property (
      !legal |=> !sync_reg && !pat_det_reg)
      else $error("aligner active under illegal setting");

    cov_sync: cover property ($rose(sync_reg));
    cov_slip: cover property (slip_take);
    cov_pat:  cover property (pat_det_reg && word_valid_reg);
  end

endmodule

// File: sra_ser_tx.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Remote serial transmitter model
// ----------------------------------------------------------------
module sra_ser_tx (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [9:0] data,
  output logic            ser_bit,
  output logic            ser_valid
);
  logic [9:0] sh_reg;
  logic [3:0] cnt_reg;
  logic       tog_reg;
  // The idle line toggles, so a stale bit can never pass for data.
  assign ser_valid = (cnt_reg != 4'h0);
  assign ser_bit   = ser_valid ? sh_reg[0] : tog_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg  <= 10'h000;
      cnt_reg <= 4'h0;
      tog_reg <= 1'b0;
    end else begin
      tog_reg <= ~tog_reg;
      if (start && cnt_reg <= 4'h1) begin
        sh_reg  <= data;
        cnt_reg <= 4'ha;
      end else if (cnt_reg != 4'h0) begin
        sh_reg  <= sh_reg >> 1;
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/1ns
module tb;
  import sra_pkg::*;
  typedef struct packed {
    sra_proto_t p;
    sra_align_t a;
    logic       w;
    logic       d;
    logic       e;
  } sra_row_t;
  logic              sys_clk;
  logic              rst_n;
  sra_cfg_t          cfg;
  sra_ch_in_t        cin;
  sra_ch_in_t  [0:0] ch_in;
  sra_ch_out_t [0:0] ch_out;
  sra_ch_out_t       co;
  logic              cfg_err;
  logic              tx_start;
  logic        [9:0] tx_data;
  logic              tx_bit;
  logic              tx_val;
  logic        [9:0] pat;
  int                err_count;
  int                checked;
  int                n;
  sra_row_t          rows [10];
  assign co = ch_out[0];
  always_comb begin
    ch_in[0] = cin;
    ch_in[0].ser_bit = tx_bit;
    ch_in[0].ser_valid = tx_val;
  end
  sra_rx_align #(.NUM_CH(1), .EQ_STATIC(3'h0)) sra_rx_align_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .ch_in(ch_in),
    .ch_out(ch_out), .cfg_err(cfg_err));
  sra_ser_tx sra_ser_tx_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .start(tx_start), .data(tx_data), .ser_bit(tx_bit), .ser_valid(tx_val));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return co.freq_locked;
      1: return co.pll_locked_n;
      2: return co.word_valid & co.pat_det;
      4: return co.run_err;
      default: return co.cdr_pwr_en;
    endcase
  endfunction
  task waitv(input int w, input logic v, input int lim);
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      chk(20'(pick(w)), 20'(v));
      finish_test();
    end
  endtask
  task send(input logic [9:0] d);
    @(posedge sys_clk);
    tx_start <= 1'b1;
    tx_data  <= d;
    @(posedge sys_clk);
    tx_start <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  task finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{PROTO_CUSTOM, AL_BITSLIP, 1'b0, 1'b0, 1'b0},
             '{PROTO_XAUI, AL_BITSLIP, 1'b0, 1'b0, 1'b1},
             '{PROTO_SONET, AL_16BIT, 1'b0, 1'b1, 1'b0},
             '{PROTO_CUSTOM, AL_16BIT, 1'b0, 1'b1, 1'b1},
             '{PROTO_CUSTOM, AL_16BIT, 1'b1, 1'b0, 1'b1},
             '{PROTO_CUSTOM, AL_10BIT, 1'b1, 1'b0, 1'b0},
             '{PROTO_SONET, AL_10BIT, 1'b1, 1'b0, 1'b1},
             '{PROTO_XAUI, AL_XAUI, 1'b1, 1'b0, 1'b0},
             '{PROTO_GIGE, AL_XAUI, 1'b1, 1'b0, 1'b1},
             '{PROTO_GIGE, AL_GIGE, 1'b1, 1'b0, 1'b0}};
    rst_n = 1'b0;
    cfg = '0;
    cin = '0;
    tx_start = 1'b0;
    tx_data = 10'h000;
    err_count = 0;
    checked = 0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk({co.pll_locked_n, co.cdr_pwr_en, co.freq_locked, co.sync}, 20'h8);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge sys_clk);
      cfg.proto <= rows[i].p;
      cfg.align_mode <= rows[i].a;
      cfg.width10 <= rows[i].w;
      cfg.pat_double <= rows[i].d;
      @(negedge sys_clk);
      chk(20'(cfg_err), 20'(rows[i].e));
    end
    @(posedge sys_clk);
    cin.ch_used <= 1'b1;
    cin.force_data <= 1'b1;
    waitv(0, 1'b1, 8);
    waitv(1, 1'b0, 260);
    chk(20'(n > 150), 20'h1);
    cin.force_data <= 1'b0;
    cin.force_ref <= 1'b1;
    waitv(0, 1'b0, 8);
    repeat (20) @(posedge sys_clk);
    #1;
    chk(20'(co.freq_locked), 20'h0);
    cin.force_ref <= 1'b0;
    cin.ppm_dev <= 11'h07d;
    cin.phase_mui <= 8'h51;
    repeat (20) @(posedge sys_clk);
    #1;
    chk(20'(co.freq_locked), 20'h0);
    cin.phase_mui <= 8'h50;
    waitv(0, 1'b1, 8);
    cin.ppm_dev <= 11'h07e;
    waitv(0, 1'b0, 8);
    cfg.ppm_sel <= 2'h1;
    waitv(0, 1'b1, 8);
    cfg.eq_dynamic <= 1'b1;
    cin.eq_ctrl <= 3'h4;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(20'(co.eq_level), 20'h4);
    cfg.proto <= PROTO_CUSTOM;
    cfg.align_mode <= AL_10BIT;
    cfg.width10 <= 1'b1;
    cfg.user_pat <= K28P5_NEG;
    cin.align_en <= 1'b1;
    send(10'h155);
    for (int k = 0; k < 2; k++) begin
      pat = (k == 0) ? K28P5_NEG : ~K28P5_NEG;
      send(pat);
      waitv(2, 1'b1, 12);
      chk(20'(co.word[9:0]), 20'(pat));
      chk(20'(co.sync), 20'h1);
    end
    // Ten zeros after a one: the run passes a threshold of five at bit six.
    @(posedge sys_clk);
    tx_start <= 1'b1;
    tx_data  <= 10'h000;
    @(posedge sys_clk);
    tx_start <= 1'b0;
    waitv(4, 1'b1, 20);
    @(posedge sys_clk);
    #1;
    chk(20'(co.run_err), 20'h0);
    repeat (8) @(posedge sys_clk);
    cin.ch_used <= 1'b0;
    waitv(3, 1'b0, 4);
    chk(20'(co.pll_locked_n), 20'h1);
    finish_test();
  end
endmodule
